/* verilog/sib_pkg.sv */
// Purpose: Shared types and constants for the inter-bank command tracker.
// Assumes: Four banks, 12-bit address, 16-bit data, 25 MHz system clock.
// Notes:   Timing figures are in ns; cycle counts are derived from them.
`default_nettype none

package sib_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int NUM_BANKS = 4;        // Banks tracked independently.
  localparam int BA_W      = 2;        // Bank address width.
  localparam int ADDR_W    = 12;       // Multiplexed address width.
  localparam int COL_W     = 8;        // Column address width.
  localparam int DQ_W      = 16;       // Data bus width.
  localparam int DQM_W     = 2;        // One mask bit per byte lane.
  localparam int AP_BIT    = 10;       // Address bit selecting auto precharge.
  localparam int CNT_W     = 4;        // Burst beat counter width.
  localparam int TMR_W     = 4;        // Per-bank timer width.
  localparam int WBUF_DEPTH = 32;      // Write beat buffer depth in words.

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;   // System clock period.
  localparam int T_RCD_NS_DEF  = 20;   // Row to column delay, minimum.
  localparam int T_RP_NS_DEF   = 20;   // Precharge period, minimum.
  localparam int T_WR_NS_DEF   = 14;   // Write recovery time, minimum.
  localparam int CAS_LAT_DEF   = 2;    // CAS latency in clocks.
  localparam logic [CNT_W-1:0] BURST_LEN_DEF = 4'h4;  // Beats per burst.
  localparam logic [CNT_W-1:0] BEAT_LAST = 4'h1;      // Final beat left.
  localparam logic [TMR_W-1:0] TMR_DONE  = 4'h1;      // Final timer tick.
  localparam logic [TMR_W-1:0] TMR_ZERO  = 4'h0;      // Timer stopped.

  // Least times round up to whole cycles, never below one cycle.
  function automatic int sib_min_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  // Command pins as sampled on the rising edge.
  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
  } sib_cmd_s;

  // One accepted write beat handed to the storage side.
  typedef struct packed {
    logic [BA_W-1:0]  ba;
    logic [COL_W-1:0] col;
    logic [DQM_W-1:0] be;
    logic [DQ_W-1:0]  data;
  } sib_wbeat_s;

  // One read beat address requested from the storage side.
  typedef struct packed {
    logic [BA_W-1:0]  ba;
    logic [COL_W-1:0] col;
  } sib_raddr_s;

  // Decoded commands.
  typedef enum logic [3:0] {
    CMD_INH, CMD_NOP, CMD_ACT, CMD_RD, CMD_WR,
    CMD_PRE, CMD_BST, CMD_REF, CMD_MRS
  } sib_cmd_e;

  // Per-bank states.
  typedef enum logic [3:0] {
    BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READ, BK_WRITE,
    BK_READ_AP, BK_WRITE_AP, BK_RECOVER, BK_PRECHARGING
  } sib_bank_e;

endpackage : sib_pkg

`default_nettype wire

/* verilog/sib_interbank.sv */
// Purpose: Per-bank state tracking, burst control and data path of a
//          four-bank synchronous DRAM, seen from behind its pins.
// Assumes: Burst length of two or more; CAS latency of two or more.
// Notes:   Write beats leave through a buffer; read data is fetched from
//          the storage side in the same cycle as the address is presented.
//
// Functional notes
// - Inhibit and no-operation let operations continue.
// - Decode active, read, write, precharge from strobes.
// - Burst terminate hits only the bursting bank.
// - Reads and writes accept either precharge variant.
// - Interrupted auto-precharge burst precharges on its own.
// - Precharge elsewhere leaves running burst untouched.
// - Read interrupts read; new data after CAS.
// - Write cuts a plain read; mask first.
// - Read cuts write; last data one before.
// - Write cuts write; last data one before.
// - Auto-precharge read cut by read: precharge now.
// - Auto-precharge read cut by write: precharge now.
// - Auto-precharge write cut by read: recover first.
// - Auto-precharge write cut by write: recover first.
// - Idle only after precharge time elapsed.
// - Row active once activation delay elapsed.
// - Auto-precharge access lasts until precharge done.
// - Terminate applies to most recent burst.
`timescale 1ns/100ps
`default_nettype none

// --------------------------------------------------------------------------
// Write beat buffer
// --------------------------------------------------------------------------
module sib_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             rstn_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];     // Storage words.
  logic [PW-1:0]    wp_q;              // Write pointer.
  logic [PW-1:0]    rp_q;              // Read pointer.
  logic [PW:0]      cnt_q;             // Words held.
  logic             push;              // Word enters this cycle.
  logic             pop;               // Word leaves this cycle.

  assign in_ready_o  = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rp_q];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Storage is written without reset; only valid words are ever read.
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end

  // Pointers wrap naturally at a power-of-two depth.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule // sib_fifo

// --------------------------------------------------------------------------
// Top: bank machines, burst engine and data path
// --------------------------------------------------------------------------
module sib_interbank #(
  parameter int T_RCD_NS = sib_pkg::T_RCD_NS_DEF,
  parameter int T_RP_NS  = sib_pkg::T_RP_NS_DEF,
  parameter int T_WR_NS  = sib_pkg::T_WR_NS_DEF,
  parameter int CAS_LAT  = sib_pkg::CAS_LAT_DEF,
  parameter logic [sib_pkg::CNT_W-1:0] BURST_LEN = sib_pkg::BURST_LEN_DEF
) (
  // Clock and reset
  input  wire logic                         clk_sys_i,
  input  wire logic                         rstn_i,
  // Command pins
  input  wire logic                         cke_i,
  input  wire sib_pkg::sib_cmd_s            cmd_i,
  input  wire logic [sib_pkg::DQM_W-1:0]    dqm_i,
  // Data pins
  input  wire logic [sib_pkg::DQ_W-1:0]     dq_i,
  output logic [sib_pkg::DQ_W-1:0]          dq_o,
  output logic                              dq_oe_o,
  // Storage side: read fetch
  output logic                              rd_req_o,
  output sib_pkg::sib_raddr_s               rd_addr_o,
  input  wire logic [sib_pkg::DQ_W-1:0]     rd_data_i,
  // Storage side: write beats
  output logic                              wb_valid_o,
  input  wire logic                         wb_ready_i,
  output sib_pkg::sib_wbeat_s               wb_beat_o,
  output logic                              wb_ovf_o,
  // Bank observation
  output var sib_pkg::sib_bank_e            bank_state_o [sib_pkg::NUM_BANKS]
);
  import sib_pkg::*;

  localparam int T_RCD_CYC = sib_min_cyc(T_RCD_NS);  // Activation cycles.
  localparam int T_RP_CYC  = sib_min_cyc(T_RP_NS);   // Precharge cycles.
  localparam int T_WR_CYC  = sib_min_cyc(T_WR_NS);   // Recovery cycles.
  localparam int RP_STAGES = CAS_LAT - 1;            // Read output stages.

  // ------------------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------------------
  // Strobe decode; chip select high overrides the other strobes.
  function automatic sib_cmd_e sib_decode(input sib_cmd_s c);
    if (c.cs_n) begin
      return CMD_INH;
    end
    case ({c.ras_n, c.cas_n, c.we_n})
      3'h7:    return CMD_NOP;
      3'h3:    return CMD_ACT;
      3'h5:    return CMD_RD;
      3'h4:    return CMD_WR;
      3'h2:    return CMD_PRE;
      3'h6:    return CMD_BST;
      3'h1:    return CMD_REF;
      default: return CMD_MRS;
    endcase
  endfunction

  // A bank with an open row can take a read or write.
  function automatic logic sib_open(input sib_bank_e s);
    return (s == BK_ACTIVE) || (s == BK_READ) || (s == BK_WRITE);
  endfunction

  sib_bank_e        st_q [NUM_BANKS];  // Bank states.
  logic [TMR_W-1:0] tmr_q [NUM_BANKS]; // Bank timers.
  logic             cke_q;             // Clock enable at the previous edge.
  sib_cmd_e         cmd;               // Command taken at this edge.
  logic [BA_W-1:0]  tgt;               // Addressed bank.
  logic             ap;                // Auto precharge or precharge-all.
  logic             rd_go;             // Read accepted.
  logic             wr_go;             // Write accepted.
  logic             go;                // Any burst accepted.
  logic             pre_go;            // Precharge command.
  logic             bst_go;            // Terminate of a running burst.
  logic             pre_kills;         // Precharge truncates running burst.
  logic             end_ev;            // Running burst ends by itself.
  logic             burst_act_q;       // More beats remain.
  logic             burst_wr_q;        // Running burst is a write.
  logic [BA_W-1:0]  burst_bank_q;      // Bank of the running burst.
  logic [COL_W-1:0] col_q;             // Column of the next beat.
  logic [CNT_W-1:0] cnt_q;             // Beats remaining.
  logic             cont;              // Running burst advances a beat.

  // Commands count only with clock enable high at both edges.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cke_q <= 1'b0;
    end else begin
      cke_q <= cke_i;
    end
  end

  assign cmd       = (cke_i && cke_q) ? sib_decode(cmd_i) : CMD_INH;
  assign tgt       = cmd_i.ba;
  assign ap        = cmd_i.addr[AP_BIT];
  assign rd_go     = (cmd == CMD_RD) && sib_open(st_q[tgt]);
  assign wr_go     = (cmd == CMD_WR) && sib_open(st_q[tgt]);
  assign go        = rd_go || wr_go;
  assign pre_go    = (cmd == CMD_PRE);
  assign bst_go    = (cmd == CMD_BST) && burst_act_q;
  assign pre_kills = pre_go && burst_act_q &&
                     (ap || (tgt == burst_bank_q));
  assign cont      = burst_act_q && !go && !bst_go && !pre_kills;
  assign end_ev    = cont && (cnt_q == BEAT_LAST);

  // ------------------------------------------------------------------------
  // Bank state machines
  // ------------------------------------------------------------------------
  for (genvar i = 0; i < NUM_BANKS; i++) begin : g_bank
    logic mine;                        // Command addresses this bank.
    logic own;                         // Running burst belongs here.
    logic cut;                         // Burst interrupted or finished.
    assign mine = (tgt == BA_W'(i));
    assign own  = burst_act_q && (burst_bank_q == BA_W'(i));
    assign cut  = (own && go && !mine) || (end_ev && own) ||
                  (bst_go && own);

    // Each bank walks its own states; timers count down to the exit.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
        st_q[i]  <= BK_IDLE;
        tmr_q[i] <= TMR_ZERO;
      end else begin
        if (tmr_q[i] != TMR_ZERO) begin
          tmr_q[i] <= tmr_q[i] - 1'b1;
        end
        case (st_q[i])
          BK_IDLE: begin
            // Precharge to an idle bank is a no-operation.
            if (cmd == CMD_ACT && mine) begin
              st_q[i]  <= BK_ACTIVATING;
              tmr_q[i] <= TMR_W'(T_RCD_CYC);
            end
          end
          BK_ACTIVATING: begin
            if (tmr_q[i] == TMR_DONE) begin
              st_q[i] <= BK_ACTIVE;
            end
          end
          BK_ACTIVE, BK_READ, BK_WRITE: begin
            if (go && mine) begin
              if (rd_go) begin
                st_q[i] <= ap ? BK_READ_AP : BK_READ;
              end else begin
                st_q[i] <= ap ? BK_WRITE_AP : BK_WRITE;
              end
            end else if (pre_go && (mine || ap)) begin
              st_q[i]  <= BK_PRECHARGING;
              tmr_q[i] <= TMR_W'(T_RP_CYC);
            end else if (cut) begin
              st_q[i] <= BK_ACTIVE;
            end
          end
          BK_READ_AP: begin
            if (cut) begin
              st_q[i]  <= BK_PRECHARGING;
              tmr_q[i] <= TMR_W'(T_RP_CYC);
            end
          end
          BK_WRITE_AP: begin
            if (cut) begin
              st_q[i]  <= BK_RECOVER;
              tmr_q[i] <= TMR_W'(T_WR_CYC);
            end
          end
          BK_RECOVER: begin
            if (tmr_q[i] == TMR_DONE) begin
              st_q[i]  <= BK_PRECHARGING;
              tmr_q[i] <= TMR_W'(T_RP_CYC);
            end
          end
          default: begin
            if (tmr_q[i] == TMR_DONE) begin
              st_q[i] <= BK_IDLE;
            end
          end
        endcase
      end
    end

    chk_act_enter: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (cmd == CMD_ACT && mine && st_q[i] == BK_IDLE)
      |=> (st_q[i] == BK_ACTIVATING) ##T_RCD_CYC (st_q[i] == BK_ACTIVE))
      else $error("activation did not reach row active in time");
    chk_ap_select: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (rd_go && mine && ap) |=> (st_q[i] == BK_READ_AP))
      else $error("read with auto precharge not tracked");
    chk_ap_concurrent: assert property (@(posedge clk_sys_i)
      disable iff (!rstn_i)
      (st_q[i] == BK_READ_AP && go && !mine)
      |=> (st_q[i] == BK_PRECHARGING) && (tmr_q[i] == TMR_W'(T_RP_CYC)))
      else $error("interrupted read did not start precharge");
    chk_wr_recover: assert property (@(posedge clk_sys_i)
      disable iff (!rstn_i)
      (st_q[i] == BK_WRITE_AP && go && !mine)
      |=> (st_q[i] == BK_RECOVER) ##T_WR_CYC
          (st_q[i] == BK_PRECHARGING))
      else $error("write recovery not kept before precharge");
    chk_rp_idle: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (st_q[i] == BK_PRECHARGING && $past(st_q[i]) != BK_PRECHARGING)
      |-> (tmr_q[i] == TMR_W'(T_RP_CYC)) ##T_RP_CYC (st_q[i] == BK_IDLE))
      else $error("bank idle before precharge time");
  end

  assign bank_state_o = st_q;

  // ------------------------------------------------------------------------
  // Burst engine
  // ------------------------------------------------------------------------
  // The newest burst always replaces the running one, whatever its bank.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      burst_act_q  <= 1'b0;
      burst_wr_q   <= 1'b0;
      burst_bank_q <= '0;
      col_q        <= '0;
      cnt_q        <= '0;
    end else if (go) begin
      burst_act_q  <= 1'b1;
      burst_wr_q   <= wr_go;
      burst_bank_q <= tgt;
      col_q        <= cmd_i.addr[COL_W-1:0] + 1'b1;
      cnt_q        <= BURST_LEN - 1'b1;
    end else if (bst_go || pre_kills) begin
      burst_act_q <= 1'b0;
    end else if (burst_act_q) begin
      col_q <= col_q + 1'b1;
      cnt_q <= cnt_q - 1'b1;
      if (cnt_q == BEAT_LAST) begin
        burst_act_q <= 1'b0;
      end
    end
  end

  chk_bst_target: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (cmd == CMD_BST && burst_act_q && !go)
    |=> !burst_act_q && st_q[$past(burst_bank_q)] != BK_READ &&
        st_q[$past(burst_bank_q)] != BK_WRITE)
    else $error("terminate did not end the running burst");
  chk_pre_other: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (pre_go && !ap && tgt != burst_bank_q && burst_act_q && cnt_q > BEAT_LAST)
    |=> burst_act_q && cnt_q == $past(cnt_q) - 1'b1)
    else $error("precharge elsewhere disturbed the burst");
  chk_nop_keep: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ((cmd == CMD_NOP || cmd == CMD_INH) && burst_act_q && cnt_q > BEAT_LAST)
    |=> burst_act_q && col_q == $past(col_q) + 1'b1)
    else $error("no-operation stopped the burst");

  // ------------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------------
  logic            rd_fire;                 // Read beat issued.
  logic [DQ_W-1:0] rp_data_q [RP_STAGES];   // Output pipeline data.
  logic            rp_vld_q  [RP_STAGES];   // Output pipeline valid.

  assign rd_fire = rd_go || (cont && !burst_wr_q);

  // Beat address goes to storage; data returns in the same cycle.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_req_o  <= 1'b0;
      rd_addr_o <= '0;
    end else begin
      rd_req_o <= rd_fire;
      if (rd_fire) begin
        rd_addr_o.ba  <= rd_go ? tgt : burst_bank_q;
        rd_addr_o.col <= rd_go ? cmd_i.addr[COL_W-1:0] : col_q;
      end
    end
  end

  // A write flushes reads in flight so the bus turns around at once.
  for (genvar s = 0; s < RP_STAGES; s++) begin : g_rpipe
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
        rp_vld_q[s]  <= 1'b0;
        rp_data_q[s] <= '0;
      end else if (s == 0) begin
        rp_vld_q[s]  <= rd_req_o && !wr_go;
        rp_data_q[s] <= rd_data_i;
      end else begin
        rp_vld_q[s]  <= rp_vld_q[(s > 0) ? s-1 : 0] && !wr_go;
        rp_data_q[s] <= rp_data_q[(s > 0) ? s-1 : 0];
      end
    end
  end

  assign dq_o    = rp_data_q[RP_STAGES-1];
  assign dq_oe_o = rp_vld_q[RP_STAGES-1];

  chk_rd_fetch: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    rd_go |=> rd_req_o && rd_addr_o.col == $past(cmd_i.addr[COL_W-1:0]))
    else $error("read beat address not issued");
  chk_wr_flush: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    wr_go |=> !dq_oe_o)
    else $error("read data still driven after write");

  // ------------------------------------------------------------------------
  // Write path
  // ------------------------------------------------------------------------
  logic       wr_fire;                 // Write beat present on the pins.
  logic       wb_in_ready;             // Buffer can take a beat.
  logic       wb_push;                 // Unmasked beat offered.
  sib_wbeat_s wb_in;                   // Beat entering the buffer.

  // The beat on the pins at an interrupting command belongs to the new
  // burst, so the old burst ends with the beat one clock earlier.
  assign wr_fire     = wr_go || (cont && burst_wr_q);
  assign wb_push     = wr_fire && (dqm_i != {DQM_W{1'b1}});
  assign wb_in.ba    = wr_go ? tgt : burst_bank_q;
  assign wb_in.col   = wr_go ? cmd_i.addr[COL_W-1:0] : col_q;
  assign wb_in.be    = ~dqm_i;
  assign wb_in.data  = dq_i;

  sib_fifo #(
    .WIDTH ($bits(sib_wbeat_s)),
    .DEPTH (WBUF_DEPTH)
  ) u_wbuf (
    .clk_sys_i   (clk_sys_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (wb_push),
    .in_ready_o  (wb_in_ready),
    .in_data_i   (wb_in),
    .out_valid_o (wb_valid_o),
    .out_ready_i (wb_ready_i),
    .out_data_o  (wb_beat_o)
  );

  // The pins cannot be stalled, so a beat meeting a full buffer is lost
  // and flagged until reset.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wb_ovf_o <= 1'b0;
    end else if (wb_push && !wb_in_ready) begin
      wb_ovf_o <= 1'b1;
    end
  end

  chk_wr_last: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (burst_act_q && burst_wr_q && wr_go && tgt != burst_bank_q)
    |=> burst_bank_q == $past(tgt) && cnt_q == BURST_LEN - 1'b1)
    else $error("interrupting write did not take over");
endmodule // sib_interbank

`default_nettype wire

/* test/sib_store_model.sv */
// Purpose: Storage side model that answers read fetches and drains writes.
// Assumes: Fetch data is wanted in the same cycle as the request pulse.
// Notes:   Fetched words encode bank and column so results are predictable.
`timescale 1ns/100ps
`default_nettype none
module sib_store_model (
  // Clock and drain control
  input  wire logic                  clk_sys_i,
  input  wire logic                  stall_i,
  // Fetch and drain handshakes
  input  wire logic                  rd_req_i,
  input  wire sib_pkg::sib_raddr_s   rd_addr_i,
  output logic [sib_pkg::DQ_W-1:0]   rd_data_o,
  output logic                       wb_ready_o
);
  import sib_pkg::*;
  logic [DQ_W-1:0] junk_q = 16'h0f0f;  // Changes every cycle when idle.
  // A stale word must never pass for a fetch, so idle data keeps moving.
  always @(posedge clk_sys_i) begin
    junk_q <= ~junk_q ^ 16'h5a5a;
  end
  assign rd_data_o  = rd_req_i ? {6'h2a, rd_addr_i} : junk_q;
  assign wb_ready_o = ~stall_i;
endmodule // sib_store_model
`default_nettype wire

/* test/testbench.sv */
// Purpose: Self-checking bench for the inter-bank command tracker.
// Assumes: Default timing parameters, each rounding to one cycle.
// Notes:   Commands are launched at a rising edge and taken at the next.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin fails++; $display("Error %s expected %h seen %h", n, e, a); end end
module testbench;
  import sib_pkg::*;
  logic clk_sys_i = 1'b0, rstn_i = 1'b0, cke_i = 1'b0, stall = 1'b0;
  sib_cmd_s cmd_i = {1'b1, 3'h7, 2'h0, 12'h000};
  logic [DQM_W-1:0] dqm_i = 2'h0;
  logic [DQ_W-1:0] dq_i = 16'h0000, dq_o, rd_data;
  logic dq_oe, rd_req, wb_valid, wb_ready, wb_ovf;
  sib_raddr_s rd_addr;
  sib_wbeat_s wb_beat;
  sib_bank_e st [NUM_BANKS];
  int fails = 0, check_count = 0, cyc = 0, pops = 0;
  sib_interbank dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .cke_i(cke_i),
    .cmd_i(cmd_i), .dqm_i(dqm_i), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe),
    .rd_req_o(rd_req), .rd_addr_o(rd_addr), .rd_data_i(rd_data),
    .wb_valid_o(wb_valid), .wb_ready_i(wb_ready), .wb_beat_o(wb_beat),
    .wb_ovf_o(wb_ovf), .bank_state_o(st));
  sib_store_model store (.clk_sys_i(clk_sys_i), .stall_i(stall),
    .rd_req_i(rd_req), .rd_addr_i(rd_addr), .rd_data_o(rd_data),
    .wb_ready_o(wb_ready));
  initial forever #20 clk_sys_i = ~clk_sys_i;
  // Counts drained beats and cuts a hang short.
  always @(posedge clk_sys_i) begin
    cyc++;
    if (wb_valid === 1'b1 && wb_ready === 1'b1) pops++;
    if (cyc == 3000) begin
      fails++;
      give_verdict();
    end
  end
  function automatic logic [15:0] exp_rd(logic [1:0] b, logic [7:0] c);
    return {6'h2a, b, c};
  endfunction
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Launches one command, then returns the pins to inhibit (chip select high).
  task automatic cmd(logic cs, logic [2:0] rcw, logic [1:0] b,
                     logic [11:0] a);
    @(posedge clk_sys_i);
    cmd_i <= {cs, rcw, b, a};
    @(posedge clk_sys_i);
    cmd_i <= {1'b1, 3'h7, 2'h0, 12'h000};
    #1;
  endtask
  task automatic t_banks();
    cmd(1'b1, 3'b011, 2'h2, 12'h000);
    `CHK("inhibit", BK_IDLE, st[2])
    cmd(1'b0, 3'b011, 2'h0, 12'h001);
    `CHK("activating", BK_ACTIVATING, st[0])
    cmd(1'b0, 3'b011, 2'h1, 12'h002);
    `CHK("active", BK_ACTIVE, st[0])
    `CHK("other bank", BK_ACTIVATING, st[1])
    $display("test banks done");
  endtask
  task automatic t_reads();
    cmd(1'b0, 3'b101, 2'h0, 12'h005);
    cmd(1'b0, 3'b101, 2'h1, 12'h410);
    `CHK("old burst", exp_rd(2'h0, 8'h06), dq_o)
    `CHK("cut bank", BK_ACTIVE, st[0])
    `CHK("ap read", BK_READ_AP, st[1])
    @(posedge clk_sys_i); #1;
    `CHK("new burst", exp_rd(2'h1, 8'h10), dq_o)
    `CHK("read drive", 1'b1, dq_oe)
    repeat (2) @(posedge clk_sys_i); #1;
    `CHK("ap precharge", BK_PRECHARGING, st[1])
    @(posedge clk_sys_i); #1;
    `CHK("idle", BK_IDLE, st[1])
    $display("test reads done");
  endtask
  task automatic t_write_ap();
    int p0;
    cmd(1'b0, 3'b011, 2'h1, 12'h000);
    p0 = pops;
    cmd(1'b0, 3'b100, 2'h0, 12'h420);
    `CHK("ap write", BK_WRITE_AP, st[0])
    // Head beat: bank 0, column 20, both lanes enabled, data zero.
    `CHK("first beat", 28'h0830000, wb_beat)
    cmd(1'b0, 3'b101, 2'h1, 12'h030);
    `CHK("recover", BK_RECOVER, st[0])
    @(posedge clk_sys_i); #1;
    `CHK("late precharge", BK_PRECHARGING, st[0])
    repeat (2) @(posedge clk_sys_i); #1;
    `CHK("beats kept", p0 + 2, pops)
    $display("test write ap done");
  endtask
  task automatic t_fill();
    int p0;
    p0 = pops;
    @(posedge clk_sys_i);
    stall <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      if (i == 8) `CHK("no overflow", 1'b0, wb_ovf)
      cmd(1'b0, 3'b100, 2'h1, 12'h000);
      repeat (2) @(posedge clk_sys_i);
      #1;
    end
    @(posedge clk_sys_i); #1;
    `CHK("overflow", 1'b1, wb_ovf)
    @(posedge clk_sys_i);
    stall <= 1'b0;
    for (int i = 0; i < 40 && wb_valid !== 1'b0; i++) @(posedge clk_sys_i);
    #1;
    `CHK("drained", p0 + 32, pops)
    $display("test fill done");
  endtask
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    cke_i  <= 1'b1;
    t_banks();
    t_reads();
    t_write_ap();
    t_fill();
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
